// >>> jai_pkg.sv
// package: constants, encodings and carrier types for the jump and increment execution block
package jai_pkg;
	localparam int JAI_PC_W = 21;
	localparam int JAI_ADDR_W = 12;
	localparam int JAI_BANK_W = 4;
	localparam logic [5:0] JAI_OP_ADD_ONE = 6'h0A;
	localparam logic [5:0] JAI_OP_SKIP_EMPTY = 6'h0F;
	localparam logic [5:0] JAI_OP_SKIP_UNLESS = 6'h12;
	localparam logic [7:0] JAI_OP_FAR_JUMP = 8'hEF;
	localparam int JAI_D_BIT = 9;
	localparam int JAI_A_BIT = 8;
	localparam logic [7:0] JAI_ACCESS_SPLIT = 8'h80;
	localparam logic [7:0] JAI_INDEX_LIMIT = 8'h5F;
	localparam logic [3:0] JAI_SFR_PAGE = 4'hF;
	localparam logic [3:0] JAI_LOW_PAGE = 4'h0;
	localparam logic [1:0] JAI_PH_Q1 = 2'h0;
	localparam logic [1:0] JAI_PH_Q2 = 2'h1;
	localparam logic [1:0] JAI_PH_Q3 = 2'h2;
	localparam logic [1:0] JAI_PH_Q4 = 2'h3;
	localparam logic [7:0] JAI_BYTE_ZERO = 8'h00;

	typedef enum logic [1:0] {
		ST_EXEC = 2'b00,
		ST_FJ_NOP = 2'b01,
		ST_SKIP = 2'b11,
		ST_SKIP2 = 2'b10
	} jai_state_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_FAR_JUMP = 3'h1,
		OP_ADD_ONE = 3'h2,
		OP_SKIP_EMPTY = 3'h3,
		OP_SKIP_UNLESS = 3'h4
	} jai_op_t;

	typedef struct packed {
		logic arith_wrap_bit;
		logic n;
		logic z;
		logic nibble_spill_bit;
		logic c;
	} jai_flags_t;

	typedef struct packed {
		logic we;
		logic [JAI_ADDR_W-1:0] addr;
		logic [7:0] data;
	} jai_wr_t;
endpackage

// >>> jai_incr.sv
// adder that adds one to a byte and derives the arithmetic flags
module jai_incr import jai_pkg::*; (
	input wire logic [7:0] val_i,
	output logic [7:0] sum_o,
	output jai_flags_t flags_o
);
	logic [8:0] wide;
	logic [4:0] low;

	always_comb begin
		wide = {1'b0, val_i} + 9'h001;
		low = {1'b0, val_i[3:0]} + 5'h01;
		sum_o = wide[7:0];
		flags_o.c = wide[8]; // see RQ4
		flags_o.nibble_spill_bit = low[4]; // see RQ4
		flags_o.n = wide[7]; // see RQ4
		flags_o.z = (wide[7:0] == JAI_BYTE_ZERO); // see RQ4
		flags_o.arith_wrap_bit = ~val_i[7] & wide[7]; // see RQ4
	end
endmodule // jai_incr

// >>> jai_exec.sv
// execution logic for far jump and the three add-one instructions
// What this block does
// RQ1: far jump loads literal into pc 20:1
// RQ2: literal low byte word one, high word two
// RQ3: far jump takes two cycles, second idle
// RQ4: add one updates carry, nibble, sign, wrap, zero
// RQ5: add one opcode is upper bits 001010
// RQ6: destination bit zero writes accumulator, else file
// RQ7: bank bit zero access bank, else pointer
// RQ8: extended set, access bank, low addresses indexed
// RQ9: add one: decode, read, compute, write
// RQ10: skip variants write result, skip on zero/nonzero
// RQ11: skip replaces fetched word by idle cycles
module jai_exec import jai_pkg::*; (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic [15:0] INSTR_I,
	input wire logic EXT_SET_EN_I,
	input wire logic [JAI_BANK_W-1:0] BANK_POINTER_I,
	input wire logic [JAI_ADDR_W-1:0] INDEX_BASE_I,
	input wire logic [7:0] RF_RDATA_I,
	output logic [1:0] PHASE_O,
	output logic RF_RE_O,
	output logic [JAI_ADDR_W-1:0] RF_RADDR_O,
	output jai_wr_t RF_WR_O,
	output logic ACC_WE_O,
	output logic [7:0] ACC_WDATA_O,
	output logic PC_WE_O,
	output logic [JAI_PC_W-1:0] PC_WDATA_O,
	output jai_flags_t FLAGS_O,
	output logic NOP_CYCLE_O,
	output logic UNSUPPORTED_O
);
	function automatic jai_op_t decode_op(input logic [15:0] w);
		jai_op_t r;
		r = OP_NONE;
		if (w[15:8] == JAI_OP_FAR_JUMP) begin
			r = OP_FAR_JUMP;
		end else if (w[15:10] == JAI_OP_ADD_ONE) begin
			r = OP_ADD_ONE; // see RQ5
		end else if (w[15:10] == JAI_OP_SKIP_EMPTY) begin
			r = OP_SKIP_EMPTY;
		end else if (w[15:10] == JAI_OP_SKIP_UNLESS) begin
			r = OP_SKIP_UNLESS;
		end
		return r;
	endfunction

	function automatic logic [JAI_ADDR_W-1:0] file_addr(
		input logic [15:0] w,
		input logic ext,
		input logic [JAI_BANK_W-1:0] bank,
		input logic [JAI_ADDR_W-1:0] base
	);
		logic [JAI_ADDR_W-1:0] r;
		r = {bank, w[7:0]}; // see RQ7
		if (!w[JAI_A_BIT]) begin
			if (ext && (w[7:0] <= JAI_INDEX_LIMIT)) begin
				r = base + {4'h0, w[7:0]}; // see RQ8
			end else if (w[7:0] < JAI_ACCESS_SPLIT) begin
				r = {JAI_LOW_PAGE, w[7:0]}; // see RQ7
			end else begin
				r = {JAI_SFR_PAGE, w[7:0]}; // see RQ7
			end
		end
		return r;
	endfunction

	function automatic logic is_incr(input jai_op_t op);
		return (op == OP_ADD_ONE) || (op == OP_SKIP_EMPTY) || (op == OP_SKIP_UNLESS);
	endfunction

	logic [1:0] phase_reg, phase_next;
	jai_state_t state_reg, state_next;
	jai_op_t op_reg, op_next;
	logic [15:0] instr_reg, instr_next;
	logic [7:0] data_reg, data_next;
	logic rf_re_reg, rf_re_next;
	logic [JAI_ADDR_W-1:0] rf_raddr_reg, rf_raddr_next;
	jai_wr_t rf_wr_reg, rf_wr_next;
	logic acc_we_reg, acc_we_next;
	logic [7:0] acc_wdata_reg, acc_wdata_next;
	logic pc_we_reg, pc_we_next;
	logic [JAI_PC_W-1:0] pc_wdata_reg, pc_wdata_next;
	jai_flags_t flags_reg, flags_next;
	logic nop_reg, nop_next;
	logic unsup_reg, unsup_next;
	logic [7:0] sum;
	jai_flags_t inc_flags;
	jai_op_t fetched_op;

	jai_incr u_incr (
		.val_i(data_reg),
		.sum_o(sum),
		.flags_o(inc_flags)
	);

	assign fetched_op = decode_op(INSTR_I);

	always_comb begin
		phase_next = phase_reg + 2'h1;
		state_next = state_reg;
		op_next = op_reg;
		instr_next = instr_reg;
		data_next = data_reg;
		rf_re_next = 1'b0;
		rf_raddr_next = rf_raddr_reg;
		rf_wr_next = rf_wr_reg;
		rf_wr_next.we = 1'b0;
		acc_we_next = 1'b0;
		acc_wdata_next = acc_wdata_reg;
		pc_we_next = 1'b0;
		pc_wdata_next = pc_wdata_reg;
		flags_next = flags_reg;
		nop_next = nop_reg;
		unsup_next = unsup_reg;
		case (phase_reg)
			JAI_PH_Q1: begin
				case (state_reg)
					ST_EXEC: begin
						instr_next = INSTR_I;
						op_next = fetched_op;
						nop_next = 1'b0;
						unsup_next = (fetched_op == OP_NONE);
						if (is_incr(fetched_op)) begin
							rf_raddr_next = file_addr(INSTR_I, EXT_SET_EN_I, BANK_POINTER_I,
								INDEX_BASE_I); // see RQ9
							rf_re_next = 1'b1; // see RQ9
						end
					end
					ST_FJ_NOP: begin
						op_next = OP_NONE; // see RQ3
						nop_next = 1'b1;
						unsup_next = 1'b0;
						state_next = ST_EXEC;
					end
					ST_SKIP: begin
						op_next = OP_NONE; // see RQ11
						nop_next = 1'b1;
						unsup_next = 1'b0;
						state_next = (fetched_op == OP_FAR_JUMP) ? ST_SKIP2 : ST_EXEC; // see RQ11
					end
					ST_SKIP2: begin
						op_next = OP_NONE; // see RQ11
						nop_next = 1'b1;
						unsup_next = 1'b0;
						state_next = ST_EXEC;
					end
					default: begin
						state_next = ST_EXEC;
					end
				endcase
			end
			JAI_PH_Q2: begin
				if (is_incr(op_reg)) begin
					data_next = RF_RDATA_I; // see RQ9
				end
			end
			JAI_PH_Q3: begin
				case (op_reg)
					OP_FAR_JUMP: begin
						pc_we_next = 1'b1; // see RQ3
						pc_wdata_next = {INSTR_I[11:0], instr_reg[7:0], 1'b0}; // see RQ1, see RQ2
						state_next = ST_FJ_NOP; // see RQ3
					end
					OP_ADD_ONE, OP_SKIP_EMPTY, OP_SKIP_UNLESS: begin
						if (instr_reg[JAI_D_BIT]) begin
							rf_wr_next.we = 1'b1; // see RQ6
							rf_wr_next.addr = rf_raddr_reg;
							rf_wr_next.data = sum;
						end else begin
							acc_we_next = 1'b1; // see RQ6
							acc_wdata_next = sum;
						end
						if (op_reg == OP_ADD_ONE) begin
							flags_next = inc_flags; // see RQ4
						end
						if ((op_reg == OP_SKIP_EMPTY) && (sum == JAI_BYTE_ZERO)) begin
							state_next = ST_SKIP; // see RQ10
						end
						if ((op_reg == OP_SKIP_UNLESS) && (sum != JAI_BYTE_ZERO)) begin
							state_next = ST_SKIP; // see RQ10
						end
					end
					default: begin
						state_next = state_reg;
					end
				endcase
			end
			default: begin
				phase_next = JAI_PH_Q1;
			end
		endcase
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			phase_reg <= JAI_PH_Q1;
			state_reg <= ST_EXEC;
			op_reg <= OP_NONE;
			instr_reg <= 16'h0000;
			data_reg <= 8'h00;
			rf_re_reg <= 1'b0;
			rf_raddr_reg <= 12'h000;
			rf_wr_reg <= '0;
			acc_we_reg <= 1'b0;
			acc_wdata_reg <= 8'h00;
			pc_we_reg <= 1'b0;
			pc_wdata_reg <= 21'h000000;
			flags_reg <= '0;
			nop_reg <= 1'b0;
			unsup_reg <= 1'b0;
		end else if (CE_I) begin
			phase_reg <= phase_next;
			state_reg <= state_next;
			op_reg <= op_next;
			instr_reg <= instr_next;
			data_reg <= data_next;
			rf_re_reg <= rf_re_next;
			rf_raddr_reg <= rf_raddr_next;
			rf_wr_reg <= rf_wr_next;
			acc_we_reg <= acc_we_next;
			acc_wdata_reg <= acc_wdata_next;
			pc_we_reg <= pc_we_next;
			pc_wdata_reg <= pc_wdata_next;
			flags_reg <= flags_next;
			nop_reg <= nop_next;
			unsup_reg <= unsup_next;
		end
	end

	assign PHASE_O = phase_reg;
	assign RF_RE_O = rf_re_reg;
	assign RF_RADDR_O = rf_raddr_reg;
	assign RF_WR_O = rf_wr_reg;
	assign ACC_WE_O = acc_we_reg;
	assign ACC_WDATA_O = acc_wdata_reg;
	assign PC_WE_O = pc_we_reg;
	assign PC_WDATA_O = pc_wdata_reg;
	assign FLAGS_O = flags_reg;
	assign NOP_CYCLE_O = nop_reg;
	assign UNSUPPORTED_O = unsup_reg;
endmodule // jai_exec

// >>> jai_exec_chk.sv
// checker: phase, write and jump idle timing of the jump and increment block
module jai_exec_chk import jai_pkg::*; (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic [15:0] INSTR_I,
	input wire logic [1:0] PHASE_O,
	input wire logic RF_RE_O,
	input wire jai_wr_t RF_WR_O,
	input wire logic ACC_WE_O,
	input wire logic PC_WE_O,
	input wire logic [JAI_PC_W-1:0] PC_WDATA_O,
	input wire jai_flags_t FLAGS_O,
	input wire logic NOP_CYCLE_O
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_idle_cycle;
		NOP_CYCLE_O [*4];
	endsequence
	sequence s_add_q4;
		PHASE_O == JAI_PH_Q4 && $past(INSTR_I[15:10], 3) == JAI_OP_ADD_ONE;
	endsequence
	property p_re_phase; RF_RE_O |-> PHASE_O == JAI_PH_Q2; endproperty
	a_re_phase: assert property (p_re_phase) else $error("read off Q2");
	property p_wr_phase; (RF_WR_O.we || ACC_WE_O || PC_WE_O) |-> PHASE_O == JAI_PH_Q4; endproperty
	a_wr_phase: assert property (p_wr_phase) else $error("write off Q4");
	property p_phase_step; !$past(RST_I) |-> PHASE_O == $past(PHASE_O) + 2'h1; endproperty
	a_phase_step: assert property (p_phase_step) else $error("phase skipped");
	property p_dest_excl; RF_WR_O.we |-> !ACC_WE_O; endproperty
	a_dest_excl: assert property (p_dest_excl) else $error("two destinations");
	property p_jump_flags; PC_WE_O |-> $stable(FLAGS_O); endproperty
	a_jump_flags: assert property (p_jump_flags) else $error("jump moved flags");
	property p_jump_nop; PC_WE_O |-> ##2 s_idle_cycle; endproperty
	a_jump_nop: assert property (p_jump_nop) else $error("no idle after jump");
	property p_jump_pc;
		PC_WE_O |-> PC_WDATA_O == {$past(INSTR_I[11:0], 1), $past(INSTR_I[7:0], 3), 1'b0};
	endproperty
	a_jump_pc: assert property (p_jump_pc) else $error("bad jump target");
	property p_add_write; s_add_q4 and !NOP_CYCLE_O |-> RF_WR_O.we ^ ACC_WE_O; endproperty
	a_add_write: assert property (p_add_write) else $error("add without write");
	property p_add_flags;
		s_add_q4 and RF_WR_O.we |-> FLAGS_O.z == (RF_WR_O.data == JAI_BYTE_ZERO)
			&& FLAGS_O.n == RF_WR_O.data[7];
	endproperty
	a_add_flags: assert property (p_add_flags) else $error("bad add flags");
endmodule // jai_exec_chk
bind jai_exec jai_exec_chk u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .INSTR_I(INSTR_I),
	.PHASE_O(PHASE_O), .RF_RE_O(RF_RE_O), .RF_WR_O(RF_WR_O), .ACC_WE_O(ACC_WE_O),
	.PC_WE_O(PC_WE_O), .PC_WDATA_O(PC_WDATA_O), .FLAGS_O(FLAGS_O), .NOP_CYCLE_O(NOP_CYCLE_O));

// >>> jai_rf_model.sv
// file register model: answers reads during the strobe, takes writes
module jai_rf_model import jai_pkg::*; (
	input wire logic clk_i,
	input wire logic re_i,
	input wire logic [JAI_ADDR_W-1:0] raddr_i,
	input wire jai_wr_t wr_i,
	output logic [7:0] rdata_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:4095];
	logic [7:0] junk_reg = 8'hA5;
	// changing pattern while not strobed
	assign rdata_o = re_i ? mem[raddr_i] : junk_reg;
	always @(posedge clk_i) begin
		junk_reg <= ~junk_reg + 8'h01;
		if (wr_i.we === 1'b1) begin
			mem[wr_i.addr] <= wr_i.data;
		end
	end
endmodule // jai_rf_model

// >>> jai_exec_tb.sv
// testbench: issues words, notes expected writes, a monitor compares them
module jai_exec_tb import jai_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic REF_CLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic CE_I = 1'b1;
	logic [15:0] INSTR_I = 16'h0000;
	logic EXT_SET_EN_I = 1'b0;
	logic [JAI_BANK_W-1:0] BANK_POINTER_I = 4'h0;
	logic [JAI_ADDR_W-1:0] INDEX_BASE_I = 12'h000;
	logic [7:0] RF_RDATA_I;
	logic [1:0] PHASE_O;
	logic RF_RE_O, ACC_WE_O, PC_WE_O, NOP_CYCLE_O, UNSUPPORTED_O;
	logic [JAI_ADDR_W-1:0] RF_RADDR_O;
	jai_wr_t RF_WR_O;
	logic [7:0] ACC_WDATA_O;
	logic [JAI_PC_W-1:0] PC_WDATA_O;
	jai_flags_t FLAGS_O;
	jai_flags_t exp_flags = 5'h00;
	int bad_count = 0;
	int samples_checked = 0;
	logic [28:0] notes [$];
	logic [7:0] bnd [4] = '{8'hFF, 8'h7F, 8'h0F, 8'h80};
	always #12.5 REF_CLK_I = ~REF_CLK_I;
	jai_exec DUT (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .CE_I(CE_I), .INSTR_I(INSTR_I),
		.EXT_SET_EN_I(EXT_SET_EN_I), .BANK_POINTER_I(BANK_POINTER_I), .INDEX_BASE_I(INDEX_BASE_I),
		.RF_RDATA_I(RF_RDATA_I), .PHASE_O(PHASE_O), .RF_RE_O(RF_RE_O), .RF_RADDR_O(RF_RADDR_O),
		.RF_WR_O(RF_WR_O), .ACC_WE_O(ACC_WE_O), .ACC_WDATA_O(ACC_WDATA_O), .PC_WE_O(PC_WE_O),
		.PC_WDATA_O(PC_WDATA_O), .FLAGS_O(FLAGS_O), .NOP_CYCLE_O(NOP_CYCLE_O),
		.UNSUPPORTED_O(UNSUPPORTED_O));
	jai_rf_model u_rf (.clk_i(REF_CLK_I), .re_i(RF_RE_O), .raddr_i(RF_RADDR_O), .wr_i(RF_WR_O),
		.rdata_o(RF_RDATA_I));
	task automatic chk(input logic [28:0] got, input logic [28:0] want);
		samples_checked++;
		if (got !== want) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked %0d mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic cyc(input logic [15:0] w1, input logic [15:0] w2);
		INSTR_I <= w1;
		repeat (2) @(posedge REF_CLK_I);
		INSTR_I <= w2;
		repeat (2) @(posedge REF_CLK_I);
	endtask
	task automatic op(input logic [5:0] opc, input logic d, input logic a, input logic e,
		input logic [7:0] v, input logic [15:0] nxt);
		logic [7:0] f, r;
		logic [3:0] bk;
		logic [11:0] bs, ad;
		f = 8'($urandom());
		bk = 4'($urandom());
		bs = 12'($urandom());
		r = v + 8'h01;
		BANK_POINTER_I <= bk;
		EXT_SET_EN_I <= e;
		INDEX_BASE_I <= bs;
		if (a) ad = {bk, f};
		else if (e && f <= JAI_INDEX_LIMIT) ad = bs + {4'h0, f};
		else ad = {(f < JAI_ACCESS_SPLIT) ? JAI_LOW_PAGE : JAI_SFR_PAGE, f};
		u_rf.mem[ad] = v;
		if (opc == JAI_OP_ADD_ONE) exp_flags = {v == 8'h7F, r[7], r == 8'h00, &v[3:0], &v};
		notes.push_back(d ? {3'b001, exp_flags, 1'b0, ad, r} : {3'b010, exp_flags, 13'h0, r});
		cyc({opc, d, a, f}, 16'h0000);
		if ((opc == JAI_OP_SKIP_EMPTY) ? r == 8'h00 : (opc == JAI_OP_SKIP_UNLESS && r != 8'h00)) begin
			cyc(nxt, nxt);
			if (nxt[15:8] == JAI_OP_FAR_JUMP) cyc(16'h2B00, 16'h0000);
		end
	endtask
	always @(negedge REF_CLK_I) begin
		if ((PC_WE_O | ACC_WE_O | RF_WR_O.we) === 1'b1) begin
			if (notes.size() == 0) chk(29'h0, 29'h1FFFFFFF);
			else chk({PC_WE_O, ACC_WE_O, RF_WR_O.we, FLAGS_O, PC_WE_O ? PC_WDATA_O : ACC_WE_O ?
				{13'h0, ACC_WDATA_O} : {1'b0, RF_WR_O.addr, RF_WR_O.data}}, notes.pop_front());
		end
	end
	initial begin
		repeat (20000) @(posedge REF_CLK_I);
		bad_count++;
		tally_and_finish();
	end
	initial begin
		logic [19:0] k;
		void'($urandom(32'h4EB8));
		repeat (6) @(posedge REF_CLK_I);
		RST_I <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			op(JAI_OP_ADD_ONE, i[0], i[1], i[2], i[3] ? 8'($urandom()) : bnd[i[1:0]], 16'h0);
		end
		$display("test add_one_op done");
		op(JAI_OP_SKIP_EMPTY, 1'b1, 1'b1, 1'b0, 8'hFF, 16'h2B00);
		op(JAI_OP_SKIP_EMPTY, 1'b0, 1'b0, 1'b0, 8'h10, 16'h0000);
		op(JAI_OP_SKIP_UNLESS, 1'b1, 1'b0, 1'b1, 8'h05, {JAI_OP_FAR_JUMP, 8'h12});
		op(JAI_OP_SKIP_UNLESS, 1'b0, 1'b1, 1'b0, 8'hFF, 16'h0000);
		$display("test skip done");
		for (int j = 0; j < 3; j++) begin
			k = 20'($urandom());
			notes.push_back({3'b100, exp_flags, k, 1'b0});
			cyc({JAI_OP_FAR_JUMP, k[7:0]}, {4'hF, k[19:8]});
			cyc(16'h2B00, 16'h2B00);
		end
		chk(29'(UNSUPPORTED_O), 29'h0);
		cyc(16'hFFFF, 16'h0000);
		chk(29'(UNSUPPORTED_O), 29'h1);
		$display("test far_jump done");
		repeat (8) @(posedge REF_CLK_I);
		chk(29'(notes.size()), 29'h0);
		tally_and_finish();
	end
endmodule // jai_exec_tb
